// >>> cskg_ctrl.sv
// sidetone, keyclick and gain soft-step control registers with their gain engines
//
// How it works
// R01: analog sidetone mute bit, resets muted
// R02: analog sidetone gain, half-dB codes, reset 0 dB
// R03: analog sidetone gain clamps at 12 dB
// R04: analog sidetone gain changes at zero crossings
// R05: analog sidetone done flag, read only, resets 0
// R06: digital sidetone mute bit, resets muted
// R07: digital sidetone gain, top bit gives -48 dB
// R08: digital sidetone gain changes at zero crossings
// R09: keyclick enable self-clears after the burst
// R10: keyclick amplitude from three-bit field
// R11: keyclick tone doubles per frequency code
// R12: keyclick lasts (code+1)*2 tone periods
// R13: adc gain steps every one or two words
// R14: with auto gain, rate bit shows low power
// R15: dac gain steps every one or two words
// R16: dac left and right done flags
// R17: adc done flag when stepping completes
// R18: with auto gain, adc flag shows saturation
// R19: auto gain or programmed gain drives adc amp
// R20: dac volume field is the stepping target
// R21: gains walk one step per event
`timescale 1ns/1ps
module cskg_ctrl #(
   parameter int CLICK_HALF = cskg_pkg::CSKG_CLICK_HALF_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   // register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata_q,
   // pins
   input  wire logic        adc_word_select,
   input  wire logic        dac_word_clock,
   input  wire logic        analog_side_zero,
   input  wire logic        digital_side_zero,
   // neighbouring codec logic
   input  wire logic        auto_gain_enable,
   input  wire logic [6:0]  auto_gain_level,
   input  wire logic        auto_gain_saturated,
   input  wire logic        auto_gain_low_power,
   input  wire logic [6:0]  adc_gain_setting,
   input  wire logic [6:0]  dac_left_volume,
   input  wire logic [6:0]  dac_right_volume,
   // controls toward the analog side
   output logic             analog_side_mute_q,
   output logic      [6:0]  analog_side_gain_q,
   output logic             digital_side_mute_q,
   output logic      [5:0]  digital_side_gain_q,
   output logic      [6:0]  adc_gain_q,
   output logic      [6:0]  dac_left_gain_q,
   output logic      [6:0]  dac_right_gain_q,
   output logic             click_tone_q,
   output logic      [2:0]  click_level_q
);

   // ==========================================================
   // pin synchronisers
   localparam int NPIN = 4;

   logic [NPIN-1:0] pin_in;
   logic [NPIN-1:0] sync1_q;
   logic [NPIN-1:0] sync2_q;
   logic [NPIN-1:0] sync3_q;
   logic [NPIN-1:0] pin_lvl_q;
   logic [NPIN-1:0] pin_lvl_d;
   logic [NPIN-1:0] pin_rise;
   logic [NPIN-1:0] pin_change;

   assign pin_in = {digital_side_zero, analog_side_zero, dac_word_clock, adc_word_select};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         // a change counts once the second and third stages agree
         always_comb
         begin
            pin_lvl_d[gi]  = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : pin_lvl_q[gi];
            pin_rise[gi]   = pin_lvl_d[gi] & ~pin_lvl_q[gi];
            pin_change[gi] = pin_lvl_d[gi] ^ pin_lvl_q[gi];
         end

         // three-stage sampling and settled level
         always_ff @(posedge clk)
         begin
            if (!reset_n)
            begin
               sync1_q[gi]   <= 1'b0;
               sync2_q[gi]   <= 1'b0;
               sync3_q[gi]   <= 1'b0;
               pin_lvl_q[gi] <= 1'b0;
            end
            else
            begin
               sync1_q[gi]   <= pin_in[gi];
               sync2_q[gi]   <= sync1_q[gi];
               sync3_q[gi]   <= sync2_q[gi];
               pin_lvl_q[gi] <= pin_lvl_d[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // registers and word-rate dividers
   cskg_pkg::cskg_side_reg_s  side_q;
   cskg_pkg::cskg_side_reg_s  side_d;
   cskg_pkg::cskg_click_reg_s click_q;
   cskg_pkg::cskg_click_reg_s click_d;
   cskg_pkg::cskg_side_reg_s  side_wr;
   cskg_pkg::cskg_click_reg_s click_wr;
   logic                      adc_half_q;
   logic                      adc_half_d;
   logic                      dac_half_q;
   logic                      dac_half_d;
   logic [15:0]               rdata_d;
   logic                      click_start;
   logic                      click_done;
   logic                      wr_side;
   logic                      wr_click;
   logic                      analog_done;
   logic                      digital_done;
   logic                      adc_done;
   logic                      dac_left_done;
   logic                      dac_right_done;
   logic                      adc_step;
   logic                      dac_step;
   logic [6:0]                adc_level;
   logic [6:0]                adc_gain_d;
   logic [6:0]                analog_target;
   logic [5:0]                digital_target;

   assign side_wr  = cskg_pkg::cskg_side_reg_s'(reg_wdata);
   assign click_wr = cskg_pkg::cskg_click_reg_s'(reg_wdata);
   assign wr_side  = reg_wr && (reg_addr == cskg_pkg::CSKG_ADDR_SIDE);
   assign wr_click = reg_wr && (reg_addr == cskg_pkg::CSKG_ADDR_CLICK);

   // software writes, hardware flags and the self-clearing click enable
   always_comb
   begin
      side_d  = side_q;
      click_d = click_q;
      if (wr_side)
      begin
         side_d.analog_side_mute  = side_wr.analog_side_mute;   // R01
         side_d.analog_side_gain  = side_wr.analog_side_gain;   // R02
         side_d.digital_side_mute = side_wr.digital_side_mute;  // R06
         side_d.digital_side_gain = side_wr.digital_side_gain;  // R07
      end
      if (click_done)
      begin
         click_d.click_enable = 1'b0;  // R09
      end
      if (wr_click)
      begin
         // a software set in the same cycle wins over the self-clear
         click_d.click_enable    = click_wr.click_enable;     // R09
         click_d.click_amplitude = click_wr.click_amplitude;  // R10
         click_d.click_frequency = click_wr.click_frequency;  // R11
         click_d.click_length    = click_wr.click_length;     // R12
         click_d.dac_step_rate   = click_wr.dac_step_rate;    // R15
         if (!auto_gain_enable)
         begin
            click_d.adc_step_rate = click_wr.adc_step_rate;  // R14
         end
      end
      side_d.analog_side_gain_done = analog_done;     // R05
      click_d.dac_left_gain_done   = dac_left_done;   // R16
      click_d.dac_right_gain_done  = dac_right_done;  // R16
      click_d.adc_gain_done        = adc_done;        // R17
   end

   // a one to an idle enable starts a burst; a set that meets the self-clear starts one too
   assign click_start = wr_click && click_wr.click_enable && (!click_q.click_enable || click_done);  // R09

   // word-rate halving for the two step rates
   always_comb
   begin
      adc_half_d = pin_rise[0] ? ~adc_half_q : adc_half_q;
      dac_half_d = pin_rise[1] ? ~dac_half_q : dac_half_q;
      adc_step   = pin_rise[0] && (!click_q.adc_step_rate || adc_half_q);  // R13
      dac_step   = pin_rise[1] && (!click_q.dac_step_rate || dac_half_q);  // R15
   end

   // ==========================================================
   // gain decode
   always_comb
   begin
      analog_target = side_q.analog_side_gain;
      if (side_q.analog_side_gain > cskg_pkg::CSKG_ANALOG_GAIN_MAX)
      begin
         analog_target = cskg_pkg::CSKG_ANALOG_GAIN_MAX;  // R03
      end
      digital_target = side_q.digital_side_gain;
      if (side_q.digital_side_gain[5])
      begin
         digital_target = cskg_pkg::CSKG_DIGITAL_GAIN_MIN;  // R07
      end
      adc_gain_d = auto_gain_enable ? auto_gain_level : adc_level;  // R19
   end

   // read data, with auto gain taking over two bits
   always_comb
   begin
      rdata_d = reg_rdata_q;
      if (reg_rd)
      begin
         case (reg_addr)
            cskg_pkg::CSKG_ADDR_SIDE:
            begin
               rdata_d    = side_q;
               rdata_d[0] = analog_done;  // R05
            end
            cskg_pkg::CSKG_ADDR_CLICK:
            begin
               rdata_d     = click_q;
               rdata_d[11] = auto_gain_enable ? auto_gain_low_power : click_q.adc_step_rate;  // R14
               rdata_d[3]  = dac_left_done;   // R16
               rdata_d[2]  = dac_right_done;  // R16
               rdata_d[0]  = auto_gain_enable ? auto_gain_saturated : adc_done;  // R18
            end
            default:
            begin
               rdata_d = 16'h0000;
            end
         endcase
      end
   end

   // register state
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         side_q      <= cskg_pkg::CSKG_SIDE_RST;
         click_q     <= cskg_pkg::CSKG_CLICK_RST;
         adc_half_q  <= 1'b0;
         dac_half_q  <= 1'b0;
         reg_rdata_q <= 16'h0000;
         adc_gain_q  <= 7'h00;
      end
      else
      begin
         side_q      <= side_d;
         click_q     <= click_d;
         adc_half_q  <= adc_half_d;
         dac_half_q  <= dac_half_d;
         reg_rdata_q <= rdata_d;
         adc_gain_q  <= adc_gain_d;
      end
   end

   // mute controls straight from the register
   assign analog_side_mute_q  = side_q.analog_side_mute;   // R01
   assign digital_side_mute_q = side_q.digital_side_mute;  // R06

   // ==========================================================
   // gain engines
   cskg_stepper #(.W(7), .RST(7'h45)) u_analog (
      .clk     (clk),
      .reset_n (reset_n),
      .step    (pin_change[2]),  // R04
      .target  (analog_target),
      .level_q (analog_side_gain_q),
      .done_q  (analog_done)
   );

   cskg_stepper #(.W(6), .RST(7'h00)) u_digital (
      .clk     (clk),
      .reset_n (reset_n),
      .step    (pin_change[3]),  // R08
      .target  (digital_target),
      .level_q (digital_side_gain_q),
      .done_q  (digital_done)
   );

   cskg_stepper #(.W(7), .RST(7'h00)) u_adc (
      .clk     (clk),
      .reset_n (reset_n),
      .step    (adc_step),
      .target  (adc_gain_setting),
      .level_q (adc_level),
      .done_q  (adc_done)
   );

   cskg_stepper #(.W(7), .RST(cskg_pkg::CSKG_DAC_VOL_RST)) u_dac_left (
      .clk     (clk),
      .reset_n (reset_n),
      .step    (dac_step),
      .target  (dac_left_volume),  // R20
      .level_q (dac_left_gain_q),
      .done_q  (dac_left_done)
   );

   cskg_stepper #(.W(7), .RST(cskg_pkg::CSKG_DAC_VOL_RST)) u_dac_right (
      .clk     (clk),
      .reset_n (reset_n),
      .step    (dac_step),
      .target  (dac_right_volume),  // R20
      .level_q (dac_right_gain_q),
      .done_q  (dac_right_done)
   );

   // ==========================================================
   // keyclick; fields from the next-value path so a burst starts with the settings it was written with
   cskg_click #(.HALF_BASE(CLICK_HALF)) u_click (
      .clk       (clk),
      .reset_n   (reset_n),
      .start     (click_start),
      .frequency (click_d.click_frequency),
      .length    (click_d.click_length),
      .amplitude (click_d.click_amplitude),
      .tone_q    (click_tone_q),
      .level_q   (click_level_q),
      .done_q    (click_done)
   );

endmodule // cskg_ctrl

// >>> cskg_pkg.sv
// constants and register layouts for the sidetone, keyclick and gain-step block
package cskg_pkg;

   // ==========================================================
   // register map
   localparam logic [5:0]  CSKG_ADDR_SIDE  = 6'h03;
   localparam logic [5:0]  CSKG_ADDR_CLICK = 6'h04;

   // ==========================================================
   // field layouts, msb first
   typedef struct packed {
      logic       analog_side_mute;       // D15
      logic [6:0] analog_side_gain;       // D14-D8
      logic       digital_side_mute;      // D7
      logic [5:0] digital_side_gain;      // D6-D1
      logic       analog_side_gain_done;  // D0, read only
   } cskg_side_reg_s;

   typedef struct packed {
      logic       click_enable;           // D15
      logic [2:0] click_amplitude;        // D14-D12
      logic       adc_step_rate;          // D11
      logic [2:0] click_frequency;        // D10-D8
      logic [3:0] click_length;           // D7-D4
      logic       dac_left_gain_done;     // D3, read only
      logic       dac_right_gain_done;    // D2, read only
      logic       dac_step_rate;          // D1
      logic       adc_gain_done;          // D0, read only
   } cskg_click_reg_s;

   // ==========================================================
   // reset values
   localparam logic [15:0] CSKG_SIDE_RST  = 16'hC580;
   localparam logic [15:0] CSKG_CLICK_RST = 16'h4410;
   localparam logic [6:0]  CSKG_DAC_VOL_RST = 7'h7F;

   // ==========================================================
   // gain decode limits, codes in step units
   localparam logic [6:0]  CSKG_ANALOG_GAIN_MAX  = 7'h5D;  // 12 dB
   localparam logic [5:0]  CSKG_DIGITAL_GAIN_MIN = 6'h20;  // -48 dB

   // ==========================================================
   // timing
   localparam int CSKG_CLK_PERIOD_NS  = 10;
   localparam int CSKG_CLICK_HALF_NS  = 8000000;           // half of a 62.5 Hz period
   localparam int CSKG_CLICK_HALF_CYC = CSKG_CLICK_HALF_NS / CSKG_CLK_PERIOD_NS;

endpackage

// >>> cskg_stepper.sv
// one gain value walking one code per step event toward its target
`timescale 1ns/1ps
module cskg_stepper #(
   parameter int         W   = 7,
   parameter logic [6:0] RST = 7'h00
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         step,
   input  wire logic [W-1:0] target,
   output logic      [W-1:0] level_q,
   output logic              done_q
);

   logic [W-1:0] level_d;
   logic         done_d;

   // one code per step event toward the target
   always_comb
   begin
      level_d = level_q;
      if (step && (level_q < target))
      begin
         level_d = level_q + {{(W-1){1'b0}}, 1'b1};  // R21
      end
      else if (step && (level_q > target))
      begin
         level_d = level_q - {{(W-1){1'b0}}, 1'b1};  // R21
      end
      done_d = (level_d == target);  // R21
   end

   // state registers
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         level_q <= RST[W-1:0];
         done_q  <= 1'b0;
      end
      else
      begin
         level_q <= level_d;
         done_q  <= done_d;
      end
   end

endmodule // cskg_stepper

// >>> cskg_click.sv
// keyclick tone burst generator
`timescale 1ns/1ps
module cskg_click #(
   parameter int HALF_BASE = cskg_pkg::CSKG_CLICK_HALF_CYC
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       start,
   input  wire logic [2:0] frequency,
   input  wire logic [3:0] length,
   input  wire logic [2:0] amplitude,
   output logic            tone_q,
   output logic [2:0]      level_q,
   output logic            done_q
);

   logic        active_q;
   logic        active_d;
   logic [19:0] half_cnt_q;
   logic [19:0] half_cnt_d;
   logic [6:0]  halves_q;
   logic [6:0]  halves_d;
   logic        tone_d;
   logic [2:0]  level_d;
   logic        done_d;
   logic [19:0] half_len;

   // half a tone period; doubles in rate per frequency code
   assign half_len = 20'(HALF_BASE >> frequency);  // R11

   // burst of (length+1)*2 periods, counted in half periods
   always_comb
   begin
      active_d   = active_q;
      half_cnt_d = half_cnt_q;
      halves_d   = halves_q;
      tone_d     = tone_q;
      done_d     = 1'b0;
      if (start && !active_q)
      begin
         active_d   = 1'b1;
         half_cnt_d = half_len - 20'h00001;
         halves_d   = {1'b0, length, 2'b11};  // R12
         tone_d     = 1'b1;
      end
      else if (active_q)
      begin
         if (half_cnt_q != 20'h00000)
         begin
            half_cnt_d = half_cnt_q - 20'h00001;
         end
         else if (halves_q == 7'h00)
         begin
            active_d = 1'b0;
            tone_d   = 1'b0;
            done_d   = 1'b1;  // R09
         end
         else
         begin
            halves_d   = halves_q - 7'h01;
            half_cnt_d = half_len - 20'h00001;
            tone_d     = ~tone_q;  // R11
         end
      end
      level_d = active_d ? amplitude : 3'h0;  // R10
   end

   // state registers
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         active_q   <= 1'b0;
         half_cnt_q <= 20'h00000;
         halves_q   <= 7'h00;
         tone_q     <= 1'b0;
         level_q    <= 3'h0;
         done_q     <= 1'b0;
      end
      else
      begin
         active_q   <= active_d;
         half_cnt_q <= half_cnt_d;
         halves_q   <= halves_d;
         tone_q     <= tone_d;
         level_q    <= level_d;
         done_q     <= done_d;
      end
   end

endmodule // cskg_click

// >>> cskg_ctrl_props.sv
// concurrent checks on the ports of the sidetone, keyclick and gain-step block
`timescale 1ns/1ps
module cskg_ctrl_props (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [5:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_q,
   input wire logic        dac_word_clock,
   input wire logic        analog_side_zero,
   input wire logic        digital_side_zero,
   input wire logic        auto_gain_enable,
   input wire logic [6:0]  auto_gain_level,
   input wire logic        analog_side_mute_q,
   input wire logic [6:0]  analog_side_gain_q,
   input wire logic        digital_side_mute_q,
   input wire logic [5:0]  digital_side_gain_q,
   input wire logic [6:0]  adc_gain_q,
   input wire logic [6:0]  dac_left_gain_q,
   input wire logic [6:0]  dac_right_gain_q,
   input wire logic        click_tone_q,
   input wire logic [2:0]  click_level_q
);
   // ==========================================================
   // shared clocking and step sequences
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // a pin that has not moved for eight cycles
   sequence s_quiet(logic pin);
      $stable(pin) [*8];
   endsequence

   // a write to the sidetone register
   sequence s_side_wr;
      reg_wr && reg_addr == cskg_pkg::CSKG_ADDR_SIDE;
   endsequence

   // ==========================================================
   // assertions
   a_unmapped_read_zero: assert property ((reg_rd && reg_addr != cskg_pkg::CSKG_ADDR_SIDE &&
      reg_addr != cskg_pkg::CSKG_ADDR_CLICK) |=> reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
   a_mute_bits_write: assert property (s_side_wr |=> analog_side_mute_q == $past(reg_wdata[15]) &&
      digital_side_mute_q == $past(reg_wdata[7])) else $error("mute bits do not follow write");
   a_analog_gain_clamp: assert property (analog_side_gain_q <= cskg_pkg::CSKG_ANALOG_GAIN_MAX)
      else $error("analog gain above clamp");
   a_digital_gain_clamp: assert property (digital_side_gain_q <= cskg_pkg::CSKG_DIGITAL_GAIN_MIN)
      else $error("digital gain beyond floor");
   a_analog_hold_quiet: assert property (s_quiet(analog_side_zero) |-> $stable(analog_side_gain_q))
      else $error("analog gain moved without crossing");
   a_digital_hold_quiet: assert property (s_quiet(digital_side_zero) |-> $stable(digital_side_gain_q))
      else $error("digital gain moved without crossing");
   a_dac_hold_quiet: assert property (s_quiet(dac_word_clock) |->
      $stable(dac_left_gain_q) && $stable(dac_right_gain_q)) else $error("dac gain moved without word clock");
   a_analog_single_step: assert property ($changed(analog_side_gain_q) |->
      (analog_side_gain_q - $past(analog_side_gain_q) == 7'h01) ||
      ($past(analog_side_gain_q) - analog_side_gain_q == 7'h01)) else $error("analog gain jumped");
   a_agc_drives_adc: assert property (auto_gain_enable |=> adc_gain_q == $past(auto_gain_level))
      else $error("adc gain not from auto gain");
   a_click_start_tone: assert property ((reg_wr && reg_addr == cskg_pkg::CSKG_ADDR_CLICK &&
      reg_wdata[15] && reg_wdata[14:12] != 3'h0 && click_level_q == 3'h0) |=>
      click_tone_q && click_level_q == $past(reg_wdata[14:12])) else $error("keyclick did not start");
endmodule // cskg_ctrl_props

bind cskg_ctrl cskg_ctrl_props props_u (
   .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .dac_word_clock(dac_word_clock),
   .analog_side_zero(analog_side_zero), .digital_side_zero(digital_side_zero),
   .auto_gain_enable(auto_gain_enable), .auto_gain_level(auto_gain_level),
   .analog_side_mute_q(analog_side_mute_q), .analog_side_gain_q(analog_side_gain_q),
   .digital_side_mute_q(digital_side_mute_q), .digital_side_gain_q(digital_side_gain_q),
   .adc_gain_q(adc_gain_q), .dac_left_gain_q(dac_left_gain_q), .dac_right_gain_q(dac_right_gain_q),
   .click_tone_q(click_tone_q), .click_level_q(click_level_q)
);

// >>> cskg_ctrl_bench.sv
// self-checking bench for the sidetone, keyclick and gain-step block
`timescale 1ns/1ps
module cskg_ctrl_bench;
   typedef struct packed {
      logic [5:0]  addr;
      logic [15:0] wdata;
      logic [15:0] exp;
   } cskg_row_s;

   // ==========================================================
   // stimulus and observed signals
   logic        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata_q;
   logic        adc_ws = 1'b0, dac_wc = 1'b0, a_zero = 1'b0, d_zero = 1'b0;
   logic        agc_en = 1'b0, agc_sat = 1'b0, agc_low = 1'b0;
   logic [6:0]  agc_lvl = 7'h00, adc_set = 7'h00, vol_l = 7'h7F, vol_r = 7'h7F;
   logic        a_mute, d_mute, tone, prev;
   logic [6:0]  a_gain, adc_g, dac_l, dac_r;
   logic [5:0]  d_gain;
   logic [2:0]  level, lvl_seen;
   int          mismatches = 0, n_compared = 0, cnt, rises;
   cskg_row_s   rows [8] = '{'{6'h04, 16'h7FF2, 16'h7FFF}, '{6'h04, 16'h0000, 16'h000D},
      '{6'h03, 16'h4580, 16'h4581}, '{6'h03, 16'h4600, 16'h4600}, '{6'h03, 16'h4601, 16'h4600},
      '{6'h05, 16'hFFFF, 16'h0000}, '{6'h03, 16'hC580, 16'hC581}, '{6'h04, 16'h4410, 16'h441D}};

   // clock and device under test
   always #5 clk = ~clk;

   cskg_ctrl #(.CLICK_HALF(8)) dut_u (
      .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .adc_word_select(adc_ws),
      .dac_word_clock(dac_wc), .analog_side_zero(a_zero), .digital_side_zero(d_zero),
      .auto_gain_enable(agc_en), .auto_gain_level(agc_lvl), .auto_gain_saturated(agc_sat),
      .auto_gain_low_power(agc_low), .adc_gain_setting(adc_set), .dac_left_volume(vol_l),
      .dac_right_volume(vol_r), .analog_side_mute_q(a_mute), .analog_side_gain_q(a_gain),
      .digital_side_mute_q(d_mute), .digital_side_gain_q(d_gain), .adc_gain_q(adc_g),
      .dac_left_gain_q(dac_l), .dac_right_gain_q(dac_r), .click_tone_q(tone), .click_level_q(level)
   );

   // ==========================================================
   // helper tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      chk(reg_rdata_q, e);
   endtask

   // toggles one pin n times, leaving time for the synchronisers
   task automatic tog(input int sel, input int n);
      repeat (n)
      begin
         case (sel)
            0: a_zero = ~a_zero;
            1: d_zero = ~d_zero;
            2: adc_ws = ~adc_ws;
            default: dac_wc = ~dac_wc;
         endcase
         repeat (8) @(negedge clk);
      end
   endtask

   task automatic final_report();
      if (mismatches == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({14'h0000, a_mute, d_mute}, 16'h0003);
      rd(6'h03, 16'hC581);
      rd(6'h04, 16'h441D);
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].exp);
      end
      // analog sidetone gain walks per crossing and clamps
      wr(6'h03, 16'h4700);
      tog(0, 1);
      chk({9'h000, a_gain}, 16'h0046);
      rd(6'h03, 16'h4700);
      tog(0, 1);
      rd(6'h03, 16'h4701);
      wr(6'h03, 16'h7F00);
      tog(0, 30);
      chk({9'h000, a_gain}, 16'h005D);
      // digital sidetone gain walks to its floor
      wr(6'h03, 16'h7F4A);
      tog(1, 1);
      chk({10'h000, d_gain}, 16'h0001);
      tog(1, 39);
      chk({10'h000, d_gain}, 16'h0020);
      chk({14'h0000, a_mute, d_mute}, 16'h0000);
      rd(6'h03, 16'h7F4B);
      // adc stepping at both rates
      adc_set = 7'h02;
      tog(2, 4);
      chk({9'h000, adc_g}, 16'h0002);
      wr(6'h04, 16'h4C10);
      adc_set = 7'h05;
      tog(2, 8);
      chk({9'h000, adc_g}, 16'h0004);
      rd(6'h04, 16'h4C1C);
      tog(2, 4);
      chk({9'h000, adc_g}, 16'h0005);
      // automatic gain control takes over status bits
      agc_lvl = 7'h33;
      agc_sat = 1'b1;
      agc_low = 1'b1;
      agc_en = 1'b1;
      repeat (3) @(negedge clk);
      chk({9'h000, adc_g}, 16'h0033);
      rd(6'h04, 16'h4C1D);
      wr(6'h04, 16'h4410);
      agc_low = 1'b0;
      agc_sat = 1'b0;
      rd(6'h04, 16'h441C);
      agc_en = 1'b0;
      repeat (3) @(negedge clk);
      rd(6'h04, 16'h4C1D);
      chk({9'h000, adc_g}, 16'h0005);
      // dac stepping toward the volume targets
      wr(6'h04, 16'h4410);
      vol_l = 7'h7C;
      vol_r = 7'h7D;
      tog(3, 4);
      chk({2'b00, dac_l, dac_r}, 16'h3EFD);
      rd(6'h04, 16'h4415);
      wr(6'h04, 16'h4412);
      tog(3, 4);
      chk({2'b00, dac_l, dac_r}, 16'h3E7D);
      rd(6'h04, 16'h441F);
      // keyclick burst length, tone periods and self clear
      wr(6'h04, 16'h9110);
      cnt = 0;
      rises = 0;
      prev = 1'b0;
      lvl_seen = 3'h0;
      repeat (60)
      begin
         if (level !== 3'h0)
         begin
            cnt++;
            lvl_seen = level;
         end
         if (tone === 1'b1 && prev !== 1'b1)
            rises++;
         prev = tone;
         @(negedge clk);
      end
      chk(cnt[15:0], 16'h0020);
      chk(rises[15:0], 16'h0004);
      chk({13'h0000, lvl_seen}, 16'h0001);
      chk({15'h0000, tone}, 16'h0000);
      rd(6'h04, 16'h111D);
      // second reset in mid run
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      rd(6'h03, 16'hC581);
      final_report();
   end

   // watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      final_report();
   end
endmodule // cskg_ctrl_bench
